//--- verilog/pwc_defs.svh
/*
 constants of the pulse width capture channel: counter tops, prescale and
 filter codes, filter depth. assumes it is included by its bare name.
*/
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH

`define PWC_TOP_WIDE      32'h0fffffff
`define PWC_TOP_NARROW    32'h0000ffff
`define PWC_DIV_SEL_W     3
`define PWC_FILT_DEPTH    3
`define PWC_OVF_W         16

`endif

//--- verilog/pwc_pkg.sv
/*
 types of the pulse width capture channel.
 assumes nothing beyond a sv compiler.
*/
package pwc_pkg;

	typedef enum logic [1:0] {PWC_GATE_NONE, PWC_GATE_LOW, PWC_GATE_HIGH} pwc_gate_t;

	typedef struct packed {
		logic      enable;
		logic      startFalling;
		logic      pinSelB;
		logic      oneShot;
		pwc_gate_t gate;
		logic [2:0] countDiv;
		logic [2:0] filterSel;
	} pwc_cfg_t;

	typedef struct packed {
		logic [31:0] count;
		logic [15:0] overflows;
	} pwc_result_t;

endpackage : pwc_pkg

//--- verilog/pwc_divider.sv
/*
 one-cycle enable pulse every 4**sel clocks for sel 0 to 5, every 1024 clocks for sel 6 and 7 (sel 0 gives every clock).
 assumes a single clock and synchronous active high reset.
*/
`timescale 1ns/1ns
`include "pwc_defs.svh"

module pwc_divider
(
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic [`PWC_DIV_SEL_W-1:0]  sel,
	output logic                            tick
);

	logic [9:0] divCnt_q;
	logic [9:0] divTop;

	assign divTop = (sel > 3'h5) ? 10'h3ff : 10'((11'h001 << ({1'b0, sel} << 1)) - 11'h001);
	assign tick   = (divCnt_q >= divTop);

	always_ff @(posedge clk)
	begin
		if (reset || tick)
			divCnt_q <= 10'h000;
		else
			divCnt_q <= divCnt_q + 10'h001;
	end

endmodule : pwc_divider

//--- verilog/pwc_capture.sv
/*
 pulse width capture channel: edge start with optional level gate,
 opposite edge end, raw count plus overflow count.
 assumes pins are synchronous to clk, config is held stable while enabled.
*/
`timescale 1ns/1ns
`include "pwc_defs.svh"

module pwc_capture
#(
	parameter bit WIDE = 1'b1
)
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire pwc_pkg::pwc_cfg_t cfg,
	input  wire logic              rearm,
	input  wire logic              channelPinA,
	input  wire logic              channelPinB,
	output logic                   running,
	output logic                   armed,
	output pwc_pkg::pwc_result_t   result,
	output logic                   captureDone,
	output logic                   overflowEvent
);

	// ************************************************************
	// count tops and filter
	// ************************************************************
	localparam logic [31:0] TOP = WIDE ? `PWC_TOP_WIDE : `PWC_TOP_NARROW;

	logic       sampleTick;
	logic       countTick;
	logic [1:0] pinRaw;
	logic [1:0] pinLvl_q;
	logic [1:0] pinLvl_d;
	logic [1:0] sh0_q;
	logic [1:0] sh1_q;
	logic [1:0] sh2_q;
	logic       filtOn;

	assign filtOn = (cfg.filterSel != 3'h0);
	assign pinRaw = {channelPinB, channelPinA};

	pwc_divider uFiltDiv
	(
		.clk   (clk),
		.reset (reset),
		.sel   (3'(cfg.filterSel - 3'h1)),
		.tick  (sampleTick)
	);

	pwc_divider uCountDiv
	(
		.clk   (clk),
		.reset (reset || !running),
		.sel   (cfg.countDiv),
		.tick  (countTick)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sh0_q <= 2'h0;
			sh1_q <= 2'h0;
			sh2_q <= 2'h0;
		end
		else if (sampleTick)
		begin
			sh0_q <= pinRaw;
			sh1_q <= sh0_q;
			sh2_q <= sh1_q;
		end
	end

	// with the filter on, a bit only follows once the last three samples agree
	always_comb
	begin
		pinLvl_d = pinLvl_q;
		for (int i = 0; i < 2; i++)
		begin
			if (!filtOn)
				pinLvl_d[i] = pinRaw[i];
			else if (sh0_q[i] == sh1_q[i] && sh1_q[i] == sh2_q[i])
				pinLvl_d[i] = sh2_q[i];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			pinLvl_q <= 2'h0;
		else
			pinLvl_q <= pinLvl_d;
	end

	// ************************************************************
	// edge and gate decode
	// ************************************************************
	logic sigNow;
	logic sigPrev_q;
	logic gateLvl;
	logic gateOk;
	logic riseEdge;
	logic fallEdge;
	logic startEdge;
	logic endEdge;
	logic wrap;

	assign sigNow    = cfg.pinSelB ? pinLvl_q[1] : pinLvl_q[0];
	assign gateLvl   = cfg.pinSelB ? pinLvl_q[0] : pinLvl_q[1];
	assign gateOk    = (cfg.gate == pwc_pkg::PWC_GATE_NONE) ||
	                   (cfg.gate == pwc_pkg::PWC_GATE_LOW  && !gateLvl) ||
	                   (cfg.gate == pwc_pkg::PWC_GATE_HIGH &&  gateLvl);
	assign riseEdge  = sigNow && !sigPrev_q;
	assign fallEdge  = !sigNow && sigPrev_q;
	assign startEdge = cfg.startFalling ? fallEdge : riseEdge;
	assign endEdge   = cfg.startFalling ? riseEdge : fallEdge;

	// ************************************************************
	// measurement state
	// ************************************************************
	typedef enum logic [1:0] {IDLE, MEASURE, DONE} pwc_state_t;

	pwc_state_t    state_q;
	logic [31:0]   count_q;
	logic [15:0]   ovf_q;
	logic          startNow;
	logic          endNow;

	assign startNow = (state_q == IDLE) && cfg.enable && startEdge && gateOk;
	assign endNow   = (state_q == MEASURE) && endEdge;
	assign wrap     = (state_q == MEASURE) && countTick && (count_q == TOP);
	assign running  = (state_q == MEASURE);
	assign armed    = (state_q == IDLE) && cfg.enable;

	always_ff @(posedge clk)
	begin
		if (reset)
			sigPrev_q <= 1'b0;
		else
			sigPrev_q <= sigNow;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state_q <= IDLE;
		else
		begin
			case (state_q)
				IDLE:    if (startNow) state_q <= MEASURE;
				MEASURE:
				begin
					if (!cfg.enable)
						state_q <= IDLE;
					else if (endNow)
						state_q <= cfg.oneShot ? DONE : IDLE;
				end
				DONE:    if (rearm || !cfg.enable) state_q <= IDLE;
				default: state_q <= IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset || startNow)
		begin
			count_q <= 32'h0;
			ovf_q   <= 16'h0;
		end
		else if (running && countTick)
		begin
			count_q <= wrap ? 32'h0 : count_q + 32'h1;
			if (wrap)
				ovf_q <= ovf_q + 16'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			result        <= '0;
			captureDone   <= 1'b0;
			overflowEvent <= 1'b0;
		end
		else
		begin
			captureDone   <= endNow;
			overflowEvent <= wrap;
			if (endNow)
			begin
				result.count     <= count_q;
				result.overflows <= ovf_q;
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_measure_end;
		(state_q == MEASURE) ##0 endEdge;
	endsequence

	a_done_after_end: assert property (@(posedge clk) disable iff (reset)
		s_measure_end |=> captureDone && result.count == $past(count_q))
		else $error("capture done or count missing after end edge");
	a_start_needs_gate: assert property (@(posedge clk) disable iff (reset)
		($rose(running)) |-> $past(gateOk && startEdge))
		else $error("measurement started without edge and gate");
	a_start_from_zero: assert property (@(posedge clk) disable iff (reset)
		$rose(running) |-> count_q == 32'h0 && ovf_q == 16'h0)
		else $error("counters not cleared at start");
	a_count_top: assert property (@(posedge clk) disable iff (reset)
		count_q <= TOP)
		else $error("count above top");
	a_wrap_ovf: assert property (@(posedge clk) disable iff (reset)
		wrap |=> count_q == 32'h0 && ovf_q == $past(ovf_q) + 16'h1 && overflowEvent)
		else $error("wrap not counted");
	a_oneshot_stop: assert property (@(posedge clk) disable iff (reset)
		s_measure_end ##0 cfg.oneShot && cfg.enable |=> state_q == DONE && !running)
		else $error("one shot did not stop");
	a_periodic_rearm: assert property (@(posedge clk) disable iff (reset)
		s_measure_end ##0 !cfg.oneShot && cfg.enable |=> armed)
		else $error("periodic did not rearm");
	a_count_hold: assert property (@(posedge clk) disable iff (reset)
		running && !countTick && !wrap |=> count_q == $past(count_q) || !running)
		else $error("count moved without tick");
	a_end_edge: assert property (@(posedge clk) disable iff (reset)
		$fell(running) && $past(cfg.enable) |-> $past(endEdge))
		else $error("measurement ended without opposite edge");

endmodule : pwc_capture

//--- verif/pwc_pulse_src.sv
/*
 far-side pulse source: capture signal and gate level.
 assumes the bench calls it just after a clock edge.
*/
`timescale 1ns/1ns
module pwc_pulse_src
(
	input  wire logic clk,
	input  wire logic selB,
	output logic      pinA,
	output logic      pinB
);
	logic sig = 1'b0;
	logic gl  = 1'b0;
	assign pinA = selB ? gl : sig;
	assign pinB = selB ? sig : gl;
	task automatic pulse(input int w, input logic idle);
		sig = ~idle;
		repeat (w) @(posedge clk);
		#1 sig = idle;
	endtask : pulse
endmodule : pwc_pulse_src

//--- verif/testbench.sv
/*
 self-checking bench: queue model of widths against captures.
 assumes the pwc package and design files are compiled first.
*/
`timescale 1ns/1ns
module testbench;
	logic                 clk = 1'b0;
	logic                 reset = 1'b1;
	logic                 rearm = 1'b0;
	pwc_pkg::pwc_cfg_t    cfg = '0;
	pwc_pkg::pwc_result_t result;
	logic                 pinA;
	logic                 pinB;
	logic                 running;
	logic                 armed;
	logic                 captureDone;
	logic                 overflowEvent;
	int                   n_mismatch = 0;
	int                   checks = 0;
	int                   nOvf = 0;
	int                   divI = 1;
	int                   e;
	int                   expQ[$];
	always #5 clk = ~clk;
	pwc_capture #(.WIDE(1'b0)) dut_u (.clk(clk), .reset(reset), .cfg(cfg), .rearm(rearm), .channelPinA(pinA),
		.channelPinB(pinB), .running(running), .armed(armed), .result(result), .captureDone(captureDone),
		.overflowEvent(overflowEvent));
	pwc_pulse_src src_u (.clk(clk), .selB(cfg.pinSelB), .pinA(pinA), .pinB(pinB));
	task automatic fail(input string m);
		n_mismatch++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask : fail
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	function automatic bit near(input logic [31:0] g, input int x);
		return g === 32'(x) || g === 32'(x + 1) || g === 32'(x - 1);
	endfunction : near
	always @(negedge clk)
	begin
		if (overflowEvent === 1'b1)
		begin
			nOvf++;
			checks++;
			if (running !== 1'b1)
				fail("overflow outside measurement");
		end
		if (captureDone === 1'b1)
		begin
			e = expQ.size() ? expQ.pop_front() : -1;
			checks++;
			if (e < 0 || !near(result.count, e % 65536) || result.overflows !== 16'(e / 65536))
				fail("capture result");
			if (running !== 1'b0)
				fail("still running after capture");
		end
	end
	task automatic setup(input logic sf, input logic sb, input logic os, input int g, input int dv, input int fl);
		cfg.enable = 1'b0;
		@(posedge clk);
		#1 cfg = {1'b0, sf, sb, os, 2'(g), 3'(dv), 3'(fl)};
		src_u.sig = sf;
		divI = 4 ** dv;
		repeat (4) @(posedge clk);
		#1 cfg.enable = 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask : setup
	task automatic meas(input int w, input bit ex);
		if (ex)
			expQ.push_back(w / divI);
		src_u.pulse(w, cfg.startFalling);
		repeat (10) @(posedge clk);
		#1 checks++;
		if (expQ.size() != 0)
			fail("missing capture");
	endtask : meas
	// ****************
	// tests
	// ****************
	initial
	begin
		void'($urandom(32'h600978ec));
		repeat (20) @(posedge clk);
		#1 reset = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		for (int d = 0; d < 6; d++)
		begin
			setup(0, 0, 0, 0, d, 0);
			meas(divI * $urandom_range(3, 10), 1);
		end
		$display("test prescale done");
		for (int g = 0; g < 3; g++)
		begin
			setup(1, 1, 0, g, 0, 0);
			src_u.gl = (g == 1);
			meas(20, g == 0);
			src_u.gl = (g == 2);
			meas(30, 1);
		end
		$display("test gate done");
		setup(0, 0, 1, 0, 0, 0);
		meas(25, 1);
		meas(25, 0);
		checks++;
		if (armed !== 1'b0 || running !== 1'b0)
			fail("one-shot still armed");
		rearm = 1'b1;
		@(posedge clk);
		#1 rearm = 1'b0;
		checks++;
		if (armed !== 1'b1)
			fail("rearm did not arm");
		meas(15, 1);
		$display("test one-shot done");
		setup(0, 0, 0, 0, 0, 1);
		meas(1, 0);
		meas(12, 1);
		$display("test filter done");
		setup(0, 0, 0, 0, 0, 0);
		nOvf = 0;
		meas(65536 + $urandom_range(20, 90), 1);
		checks++;
		if (nOvf != 1)
			fail("overflow events");
		$display("test overflow done");
		test_done();
	end
	initial
	begin
		#950_000;
		fail("watchdog");
		test_done();
	end
endmodule : testbench
